// ===== design/tzs_pkg.sv
// shared constants for the three-zone temperature sensor readout
package tzs_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // register pointer values
    localparam logic [7:0] PTR_STATUS = 8'h02;
    localparam logic [7:0] PTR_CONFIG = 8'h03;
    localparam logic [7:0] PTR_ONESHOT = 8'h0f;
    localparam logic [7:0] PTR_LOC_HI = 8'h10;
    localparam logic [7:0] PTR_R1_HI = 8'h11;
    localparam logic [7:0] PTR_R2_HI = 8'h12;
    localparam logic [7:0] PTR_LOC_LO = 8'h20;
    localparam logic [7:0] PTR_R1_LO = 8'h21;
    localparam logic [7:0] PTR_R2_LO = 8'h22;
    localparam logic [7:0] PTR_MFR_ID = 8'hfe;
    localparam logic [7:0] PTR_REV_ID = 8'hff;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_WMASK = 8'h76;
    localparam logic [6:0] SLAVE_ADDR = 7'h2b;
    // field positions
    localparam int unsigned STAT_BUSY_BIT = 7;
    localparam int unsigned STAT_R2M_BIT = 1;
    localparam int unsigned STAT_R1M_BIT = 0;
    localparam int unsigned CFG_STOP_BIT = 6;
    localparam int unsigned CFG_CRH_BIT = 5;
    localparam int unsigned CFG_CRL_BIT = 4;
    localparam int unsigned CFG_R2UNS_BIT = 2;
    localparam int unsigned CFG_R1UNS_BIT = 1;
    // fault readings
    localparam logic [15:0] FAULT_SIGNED = 16'h8000;
    localparam logic [15:0] FAULT_UNSIGNED = 16'hffe0;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    // conversion timing in milliseconds
    localparam int unsigned LOCAL_MS = 14;
    localparam int unsigned REMOTE_MS = 26;
    localparam int unsigned TIMEOUT_MS = 35;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned LOCAL_CYC = LOCAL_MS * MS_CYCLES;
    localparam int unsigned REMOTE_CYC = REMOTE_MS * MS_CYCLES;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * MS_CYCLES;
    // idle gap after a sequence for rate codes 1..3, in ms
    localparam int unsigned IDLE_MS_1 = 66;
    localparam int unsigned IDLE_MS_2 = 200;
    localparam int unsigned IDLE_MS_3 = 934;
    localparam int unsigned IDLE_CYC_1 = IDLE_MS_1 * MS_CYCLES;
    localparam int unsigned IDLE_CYC_2 = IDLE_MS_2 * MS_CYCLES;
    localparam int unsigned IDLE_CYC_3 = IDLE_MS_3 * MS_CYCLES;
endpackage : tzs_pkg

// ===== design/tzs_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ns
module tzs_sync
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : tzs_sync

// ===== design/tzs_readout.sv
// smbus slave and conversion sequencer of the temperature sensor
`timescale 1ns/1ns
// Overview of operation
// - full three-channel sequence takes 66 ms
// - channels visited in fixed round robin
// - busy bit high only while converting
// - slower rates add idle gap between sequences
// - pointer and config reset to zero
// - temperatures read zero until first sequence
// - clock line input only, never stretched
// - fixed seven-bit address 0101011
// - data line driven low only
// - remote result 11 bits, left justified
// - local result 10 bits, left justified
// - local reading wraps, never saturates
// - integer upper byte, fraction top lower
// - missing diode loads fault code, sets flag
// - pointer selects register, holds last value
// - read with address only uses pointer
// - msb first, ack or nack accepted
// - high byte read freezes low byte
// - repeated high reads recapture low byte
// - shutdown converts only on one-shot
// - stuck-low lines time out to idle
// - start recognised anywhere, then address
// - one-shot write converts once, reads zero
module tzs_readout
#(
    parameter int unsigned LOCAL_CYC = tzs_pkg::LOCAL_CYC,
    parameter int unsigned REMOTE_CYC = tzs_pkg::REMOTE_CYC,
    parameter int unsigned TIMEOUT_CYC = tzs_pkg::TIMEOUT_CYC,
    parameter int unsigned IDLE_CYC_1 = tzs_pkg::IDLE_CYC_1,
    parameter int unsigned IDLE_CYC_2 = tzs_pkg::IDLE_CYC_2,
    parameter int unsigned IDLE_CYC_3 = tzs_pkg::IDLE_CYC_3,
    parameter logic [7:0] MFR_ID = 8'h5a,
    parameter logic [7:0] REV_ID = 8'h3c
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic [9:0] i_local_code,
    input wire logic [10:0] i_remote_one_code,
    input wire logic [10:0] i_remote_two_code,
    input wire logic i_remote_one_fault,
    input wire logic i_remote_two_fault
);
    // MFR_ID and REV_ID defaults are arbitrary values

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        TZS_ST_IDLE, TZS_ST_LOCAL, TZS_ST_REM1, TZS_ST_REM2, TZS_ST_GAP
    } tzs_conv_t;
    typedef enum logic [2:0] {
        TZS_BS_IDLE, TZS_BS_ADDR, TZS_BS_AACK, TZS_BS_WBYTE, TZS_BS_WACK,
        TZS_BS_RBYTE, TZS_BS_RACK
    } tzs_bus_t;

    tzs_conv_t conv_r, conv_nxt;
    logic [31:0] timer_r, timer_nxt;
    logic [15:0] loc_r, loc_nxt;
    logic [15:0] r1_r, r1_nxt;
    logic [15:0] r2_r, r2_nxt;
    logic r1_miss_r, r1_miss_nxt;
    logic r2_miss_r, r2_miss_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic oneshot_r, oneshot_nxt;
    logic [7:0] loc_lo_r, loc_lo_nxt;
    logic [7:0] r1_lo_r, r1_lo_nxt;
    logic [7:0] r2_lo_r, r2_lo_nxt;
    logic [2:0] frz_r, frz_nxt;
    tzs_bus_t bus_r, bus_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic rd_r, rd_nxt;
    logic first_r, first_nxt;
    logic sda_low_r, sda_low_nxt;
    logic [31:0] to_r, to_nxt;
    logic scl_q_r, sda_q_r;
    logic scl_s, sda_s;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [31:0] gap_cyc;
    logic [7:0] rd_data;

    ////////////////////////////////////////////////////////////////////////
    // pins come from the host's domain
    tzs_sync u_sync_scl
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_scl),
        .o_sync(scl_s)
    );
    tzs_sync u_sync_sda
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_sda),
        .o_sync(sda_s)
    );

    assign scl_rise = scl_s && !scl_q_r;
    assign scl_fall = !scl_s && scl_q_r;
    assign start_ev = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_ev = scl_s && scl_q_r && !sda_q_r && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    always_comb
    begin
        unique case ({cfg_r[tzs_pkg::CFG_CRH_BIT], cfg_r[tzs_pkg::CFG_CRL_BIT]})
            2'b00: gap_cyc = 32'd0;
            2'b01: gap_cyc = IDLE_CYC_1;
            2'b10: gap_cyc = IDLE_CYC_2;
            2'b11: gap_cyc = IDLE_CYC_3;
        endcase
    end

    always_comb
    begin
        conv_nxt = conv_r;
        timer_nxt = timer_r;
        loc_nxt = loc_r;
        r1_nxt = r1_r;
        r2_nxt = r2_r;
        r1_miss_nxt = r1_miss_r;
        r2_miss_nxt = r2_miss_r;
        unique case (conv_r)
            TZS_ST_IDLE:
            begin
                // standby waits for a one-shot request
                if (!cfg_r[tzs_pkg::CFG_STOP_BIT] || oneshot_r)
                begin
                    conv_nxt = TZS_ST_LOCAL;
                    timer_nxt = LOCAL_CYC - 1;
                end
            end
            TZS_ST_LOCAL:
            begin
                if (timer_r == 32'd0)
                begin
                    // raw code stored, wraps past +127
                    loc_nxt = {i_local_code, 6'h00};
                    conv_nxt = TZS_ST_REM1;
                    timer_nxt = REMOTE_CYC - 1;
                end
                else
                    timer_nxt = timer_r - 32'd1;
            end
            TZS_ST_REM1:
            begin
                if (timer_r == 32'd0)
                begin
                    r1_miss_nxt = i_remote_one_fault;
                    if (i_remote_one_fault)
                        r1_nxt = cfg_r[tzs_pkg::CFG_R1UNS_BIT] ?
                            tzs_pkg::FAULT_UNSIGNED : tzs_pkg::FAULT_SIGNED;
                    else
                        r1_nxt = {i_remote_one_code, 5'h00};
                    conv_nxt = TZS_ST_REM2;
                    timer_nxt = REMOTE_CYC - 1;
                end
                else
                    timer_nxt = timer_r - 32'd1;
            end
            TZS_ST_REM2:
            begin
                if (timer_r == 32'd0)
                begin
                    r2_miss_nxt = i_remote_two_fault;
                    if (i_remote_two_fault)
                        r2_nxt = cfg_r[tzs_pkg::CFG_R2UNS_BIT] ?
                            tzs_pkg::FAULT_UNSIGNED : tzs_pkg::FAULT_SIGNED;
                    else
                        r2_nxt = {i_remote_two_code, 5'h00};
                    // 14+26+26 ms per sequence
                    if (gap_cyc == 32'd0 || cfg_r[tzs_pkg::CFG_STOP_BIT])
                        conv_nxt = TZS_ST_IDLE;
                    else
                    begin
                        conv_nxt = TZS_ST_GAP;
                        timer_nxt = gap_cyc - 1;
                    end
                end
                else
                    timer_nxt = timer_r - 32'd1;
            end
            TZS_ST_GAP:
            begin
                if (timer_r == 32'd0 || cfg_r[tzs_pkg::CFG_STOP_BIT])
                    conv_nxt = TZS_ST_IDLE;
                else
                    timer_nxt = timer_r - 32'd1;
            end
            default:
                conv_nxt = TZS_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register read mux; undefined pointers read zero
    always_comb
    begin
        unique case (ptr_r)
            tzs_pkg::PTR_STATUS:
                rd_data = {conv_r != TZS_ST_IDLE && conv_r != TZS_ST_GAP,
                    5'h00, r2_miss_r, r1_miss_r};
            tzs_pkg::PTR_CONFIG: rd_data = cfg_r;
            tzs_pkg::PTR_LOC_HI: rd_data = loc_r[15:8];
            tzs_pkg::PTR_R1_HI: rd_data = r1_r[15:8];
            tzs_pkg::PTR_R2_HI: rd_data = r2_r[15:8];
            // low bytes come from the frozen copy while locked
            tzs_pkg::PTR_LOC_LO: rd_data = frz_r[0] ? loc_lo_r : loc_r[7:0];
            tzs_pkg::PTR_R1_LO: rd_data = frz_r[1] ? r1_lo_r : r1_r[7:0];
            tzs_pkg::PTR_R2_LO: rd_data = frz_r[2] ? r2_lo_r : r2_r[7:0];
            tzs_pkg::PTR_MFR_ID: rd_data = MFR_ID;
            tzs_pkg::PTR_REV_ID: rd_data = REV_ID;
            default: rd_data = 8'h00; // one-shot reads zero
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // smbus slave; only sda is ever driven, scl is sampled
    always_comb
    begin
        bus_nxt = bus_r;
        shift_nxt = shift_r;
        bit_nxt = bit_r;
        rd_nxt = rd_r;
        first_nxt = first_r;
        sda_low_nxt = sda_low_r;
        ptr_nxt = ptr_r;
        cfg_nxt = cfg_r;
        oneshot_nxt = oneshot_r && conv_r == TZS_ST_IDLE;
        loc_lo_nxt = loc_lo_r;
        r1_lo_nxt = r1_lo_r;
        r2_lo_nxt = r2_lo_r;
        frz_nxt = frz_r;
        to_nxt = (!scl_s || !sda_s) ? to_r + 32'd1 : 32'd0;
        if (to_r >= TIMEOUT_CYC - 1)
        begin
            // stuck bus: release and go idle
            bus_nxt = TZS_BS_IDLE;
            sda_low_nxt = 1'b0;
            to_nxt = 32'd0;
        end
        else if (start_ev)
        begin
            bus_nxt = TZS_BS_ADDR;
            bit_nxt = 4'd0;
            sda_low_nxt = 1'b0;
        end
        else if (stop_ev)
        begin
            bus_nxt = TZS_BS_IDLE;
            sda_low_nxt = 1'b0;
        end
        else
        begin
            unique case (bus_r)
                TZS_BS_IDLE: ;
                TZS_BS_ADDR, TZS_BS_WBYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s}; // msb first
                        bit_nxt = bit_r + 4'd1;
                    end
                    else if (scl_fall && bit_r == 4'd8)
                    begin
                        bit_nxt = 4'd0;
                        if (bus_r == TZS_BS_ADDR)
                        begin
                            if (shift_r[7:1] == tzs_pkg::SLAVE_ADDR)
                            begin
                                rd_nxt = shift_r[0];
                                first_nxt = 1'b1;
                                sda_low_nxt = 1'b1;
                                bus_nxt = TZS_BS_AACK;
                            end
                            else
                                bus_nxt = TZS_BS_IDLE;
                        end
                        else
                        begin
                            sda_low_nxt = 1'b1;
                            bus_nxt = TZS_BS_WACK;
                            if (first_r)
                                ptr_nxt = shift_r;
                            else if (ptr_r == tzs_pkg::PTR_CONFIG)
                                cfg_nxt = shift_r & tzs_pkg::CONFIG_WMASK;
                            else if (ptr_r == tzs_pkg::PTR_ONESHOT)
                                oneshot_nxt = cfg_r[tzs_pkg::CFG_STOP_BIT];
                            first_nxt = 1'b0;
                        end
                    end
                end
                TZS_BS_AACK, TZS_BS_WACK:
                begin
                    if (scl_fall)
                    begin
                        sda_low_nxt = 1'b0;
                        bus_nxt = TZS_BS_WBYTE;
                        if (bus_r == TZS_BS_AACK && rd_r)
                        begin
                            // read uses the latched pointer
                            shift_nxt = rd_data;
                            sda_low_nxt = !rd_data[7];
                            bit_nxt = 4'd1;
                            bus_nxt = TZS_BS_RBYTE;
                            unique case (ptr_r)
                                tzs_pkg::PTR_LOC_HI:
                                begin
                                    loc_lo_nxt = loc_r[7:0];
                                    frz_nxt[0] = 1'b1;
                                end
                                tzs_pkg::PTR_R1_HI:
                                begin
                                    r1_lo_nxt = r1_r[7:0];
                                    frz_nxt[1] = 1'b1;
                                end
                                tzs_pkg::PTR_R2_HI:
                                begin
                                    r2_lo_nxt = r2_r[7:0];
                                    frz_nxt[2] = 1'b1;
                                end
                                tzs_pkg::PTR_LOC_LO: frz_nxt[0] = 1'b0;
                                tzs_pkg::PTR_R1_LO: frz_nxt[1] = 1'b0;
                                tzs_pkg::PTR_R2_LO: frz_nxt[2] = 1'b0;
                                default: ;
                            endcase
                        end
                    end
                end
                TZS_BS_RBYTE:
                begin
                    if (scl_fall)
                    begin
                        if (bit_r == 4'd8)
                        begin
                            sda_low_nxt = 1'b0;
                            bus_nxt = TZS_BS_RACK;
                        end
                        else
                        begin
                            sda_low_nxt = !shift_r[7 - bit_r[2:0]];
                            bit_nxt = bit_r + 4'd1;
                        end
                    end
                end
                TZS_BS_RACK:
                begin
                    // ack or nack both end the byte quietly
                    if (scl_fall)
                        bus_nxt = TZS_BS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            conv_r <= TZS_ST_IDLE;
            timer_r <= 32'd0;
            loc_r <= tzs_pkg::TEMP_RESET;
            r1_r <= tzs_pkg::TEMP_RESET;
            r2_r <= tzs_pkg::TEMP_RESET;
            r1_miss_r <= 1'b0;
            r2_miss_r <= 1'b0;
            cfg_r <= tzs_pkg::CONFIG_RESET;
            ptr_r <= tzs_pkg::PTR_RESET;
            oneshot_r <= 1'b0;
            loc_lo_r <= 8'h00;
            r1_lo_r <= 8'h00;
            r2_lo_r <= 8'h00;
            frz_r <= 3'h0;
            bus_r <= TZS_BS_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'd0;
            rd_r <= 1'b0;
            first_r <= 1'b0;
            sda_low_r <= 1'b0;
            to_r <= 32'd0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            conv_r <= conv_nxt;
            timer_r <= timer_nxt;
            loc_r <= loc_nxt;
            r1_r <= r1_nxt;
            r2_r <= r2_nxt;
            r1_miss_r <= r1_miss_nxt;
            r2_miss_r <= r2_miss_nxt;
            cfg_r <= cfg_nxt;
            ptr_r <= ptr_nxt;
            oneshot_r <= oneshot_nxt;
            loc_lo_r <= loc_lo_nxt;
            r1_lo_r <= r1_lo_nxt;
            r2_lo_r <= r2_lo_nxt;
            frz_r <= frz_nxt;
            bus_r <= bus_nxt;
            shift_r <= shift_nxt;
            bit_r <= bit_nxt;
            rd_r <= rd_nxt;
            first_r <= first_nxt;
            sda_low_r <= sda_low_nxt;
            to_r <= to_nxt;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // open drain: output is always low, enable pulls
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_low_r;
endmodule : tzs_readout

// ===== verification/tzs_readout_properties.sv
// pin-level checker for the sensor readout
`timescale 1ns/1ns
module tzs_readout_properties
#(
    parameter int unsigned TIMEOUT_CYC = 2000
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    // clock-low run length, margin covers sync delay
    logic [31:0] low_cnt_r;
    logic [31:0] low_cnt_nxt;
    always_comb
    begin
        low_cnt_nxt = i_scl ? 32'h0 : low_cnt_r + 32'h1;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            low_cnt_r <= 32'h0;
        else
            low_cnt_r <= low_cnt_nxt;
    end
    ////////////////////////////////////////
    property p_sda_zero;
        o_sda == 1'b0;
    endproperty
    a_sda_zero: assert property (p_sda_zero)
        else $error("data pin value not zero");
    property p_reset_idle;
        $rose(i_rst_b) |-> !o_sda_oe [*3];
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("data line driven after reset");
    property p_oe_rise;
        $rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("drive began outside clock low");
    property p_oe_fell;
        $fell(o_sda_oe) |-> !i_scl && !$past(i_scl, 2);
    endproperty
    a_oe_fell: assert property (p_oe_fell)
        else $error("drive ended outside clock low");
    property p_oe_hold;
        $rose(o_sda_oe) |=> o_sda_oe [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("driven bit did not stand");
    property p_stable_high;
        i_scl && $past(i_scl) |-> $stable(o_sda_oe);
    endproperty
    a_stable_high: assert property (p_stable_high)
        else $error("data changed while clock high");
    property p_timeout;
        low_cnt_r >= TIMEOUT_CYC + 10 |-> !o_sda_oe;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("line not released after timeout");
    property p_stop_idle;
        $rose(i_sda) && i_scl && $past(i_scl) |=> !o_sda_oe [*4];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("drive during stop");
    c_drive: cover property ($rose(o_sda_oe));
    c_timeout: cover property (low_cnt_r == TIMEOUT_CYC + 10);
    c_stop: cover property ($rose(i_sda) && i_scl);
endmodule : tzs_readout_properties

// ===== verification/tzs_host.sv
// smbus host model driving the sensor pins
`timescale 1ns/1ns
module tzs_host
(
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // 16 system cycles a bit gives a 160 ns link clock
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic half();
        repeat (8) @(negedge i_clk_sys);
    endtask : half
    // also a repeated start
    task automatic start();
        o_sda = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b0;
        half();
        o_scl = 1'b0;
    endtask : start
    task automatic bit_io(input logic b, output logic s);
        o_sda = b;
        half();
        o_scl = 1'b1;
        half();
        s = i_sda;
        o_scl = 1'b0;
    endtask : bit_io
    // msb first
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wbyte
    // one byte, then ack or nack
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask : rbyte
    task automatic stop();
        o_sda = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b1;
        half();
    endtask : stop
endmodule : tzs_host

// ===== verification/tzs_readout_tb_top.sv
// self-checking bench for the sensor readout
`timescale 1ns/1ns
module tzs_readout_tb_top;
    // short slots keep the run small
    localparam int unsigned LOC = 2000;
    localparam int unsigned REM = 3000;
    localparam int unsigned TMO = 2000;
    localparam int unsigned SEQ = LOC + 2 * REM;
    localparam logic [6:0] ADR = tzs_pkg::SLAVE_ADDR;
    logic clk, rst_b, scl, sda_h, sda, sda_o, sda_oe;
    logic [9:0] loc_code;
    logic [10:0] r1_code, r2_code;
    logic r1_flt, r2_flt;
    int miscompares, n_tests;
    assign sda = sda_h & ~sda_oe;
    tzs_readout #(.LOCAL_CYC(LOC), .REMOTE_CYC(REM), .TIMEOUT_CYC(TMO),
        .IDLE_CYC_1(4000), .IDLE_CYC_2(20), .IDLE_CYC_3(30)) uut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_o), .o_sda_oe(sda_oe), .i_local_code(loc_code),
        .i_remote_one_code(r1_code), .i_remote_two_code(r2_code),
        .i_remote_one_fault(r1_flt), .i_remote_two_fault(r2_flt));
    tzs_host host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic a0, a1, a2;
        host.start();
        host.wbyte({ADR, 1'b0}, a0);
        host.wbyte(p, a1);
        host.wbyte(d, a2);
        host.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic a0, a1, a2;
        logic [7:0] d;
        host.start();
        host.wbyte({ADR, 1'b0}, a0);
        host.wbyte(p, a1);
        host.start();
        host.wbyte({ADR, 1'b1}, a2);
        host.rbyte(1'b1, d);
        host.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
        chk(d, exp);
    endtask : rd
    task automatic wait_seq();
        repeat (SEQ) @(negedge clk);
    endtask : wait_seq
    ////////////////////////////////////////
    task automatic t_power_on();
        logic a;
        logic [7:0] d;
        host.start();
        host.wbyte({ADR, 1'b1}, a);
        host.rbyte(1'b0, d);
        host.stop();
        chk({7'h0, a}, 8'h01);
        chk(d, 8'h00);
        chk({7'h0, sda_o}, 8'h00);
        rd(tzs_pkg::PTR_LOC_HI, 8'h00);
        rd(tzs_pkg::PTR_R1_HI, 8'h00);
        rd(tzs_pkg::PTR_STATUS, 8'h80);
        rd(tzs_pkg::PTR_CONFIG, 8'h00);
        $display("test power_on done");
    endtask : t_power_on
    task automatic t_results();
        wait_seq();
        rd(tzs_pkg::PTR_LOC_HI, 8'h7d);
        rd(tzs_pkg::PTR_LOC_LO, 8'h00);
        rd(tzs_pkg::PTR_R1_HI, 8'h7d);
        rd(tzs_pkg::PTR_R1_LO, 8'h20);
        rd(tzs_pkg::PTR_R2_HI, 8'h80);
        rd(tzs_pkg::PTR_R2_LO, 8'h00);
        rd(tzs_pkg::PTR_STATUS, 8'h82);
        $display("test results done");
    endtask : t_results
    task automatic t_lock();
        rd(tzs_pkg::PTR_R1_HI, 8'h7d);
        r1_code = 11'h3ef;
        wait_seq();
        rd(tzs_pkg::PTR_R1_LO, 8'h20);
        rd(tzs_pkg::PTR_R1_LO, 8'he0);
        rd(tzs_pkg::PTR_R1_HI, 8'h7d);
        r1_code = 11'h001;
        wait_seq();
        rd(tzs_pkg::PTR_R1_HI, 8'h00);
        rd(tzs_pkg::PTR_R1_LO, 8'h20);
        $display("test lock done");
    endtask : t_lock
    task automatic t_standby();
        wr(tzs_pkg::PTR_CONFIG, 8'hff);
        rd(tzs_pkg::PTR_CONFIG, 8'h76);
        wr(tzs_pkg::PTR_CONFIG, 8'h40);
        wait_seq();
        rd(tzs_pkg::PTR_STATUS, 8'h02);
        rd(tzs_pkg::PTR_R2_HI, 8'h80);
        wr(tzs_pkg::PTR_CONFIG, 8'h44);
        wr(tzs_pkg::PTR_ONESHOT, 8'h5a);
        rd(tzs_pkg::PTR_STATUS, 8'h82);
        rd(tzs_pkg::PTR_ONESHOT, 8'h00);
        wait_seq();
        rd(tzs_pkg::PTR_R2_HI, 8'hff);
        rd(tzs_pkg::PTR_R2_LO, 8'he0);
        rd(tzs_pkg::PTR_STATUS, 8'h02);
        // continuous with idle gap: read lands inside the gap
        r1_flt = 1'b1;
        wr(tzs_pkg::PTR_CONFIG, 8'h14);
        wait_seq();
        rd(tzs_pkg::PTR_STATUS, 8'h03);
        rd(tzs_pkg::PTR_R1_HI, 8'h80);
        wr(tzs_pkg::PTR_CONFIG, 8'h44);
        $display("test standby done");
    endtask : t_standby
    task automatic t_refuse();
        logic a;
        host.start();
        host.wbyte({7'h2a, 1'b0}, a);
        host.stop();
        chk({7'h0, a}, 8'h00);
        wr(8'h40, 8'h5a);
        rd(8'h40, 8'h00);
        // clock parked low while the device drives a zero
        host.start();
        host.wbyte({ADR, 1'b1}, a);
        repeat (TMO + 100) @(negedge clk);
        chk({7'h0, sda_oe}, 8'h00);
        host.stop();
        rd(tzs_pkg::PTR_CONFIG, 8'h44);
        $display("test refuse done");
    endtask : t_refuse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #900_000;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        rst_b = 1'b0;
        loc_code = 10'h1f4;
        r1_code = 11'h3e9;
        r2_code = 11'h123;
        r1_flt = 1'b0;
        r2_flt = 1'b1;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_power_on();
        t_results();
        t_lock();
        t_standby();
        t_refuse();
        wrap_up();
    end
endmodule : tzs_readout_tb_top
bind tzs_readout tzs_readout_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));
